// ### core/bts_pkg.sv
// Package of constants and types for the boot and thermal supervisor
package bts_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRIP_DEGLITCH_NS = 1000;
  localparam int TRIP_DEGLITCH_CYC = (TRIP_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIM_SETTLE_NS = 500;
  localparam int TRIM_SETTLE_CYC = (TRIM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERSIST_NS = 2000;
  localparam int PERSIST_CYC = (PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;

  // ****************************************
  // Address and pin field layout
  // ****************************************
  localparam int ADDR_W = 7;
  localparam int STRAP_W = 2;
  localparam int DBG_W = 2;
  localparam int GPIO_N = 8;
  localparam int PORT_N = 6;
  localparam logic [ADDR_W-1:0] ADDR1_BASE_RST = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR2_BASE_RST = 7'h38;

  // ****************************************
  // General pin modes
  // ****************************************
  typedef enum logic [2:0] {
    BTS_PIN_IN_DIG = 3'b000,
    BTS_PIN_IN_ANA = 3'b001,
    BTS_PIN_PUSH = 3'b010,
    BTS_PIN_WEAK = 3'b011,
    BTS_PIN_ODRAIN = 3'b100
  } bts_pin_mode_t;

  // ****************************************
  // Boot sequence states
  // ****************************************
  typedef enum logic [3:0] {
    BTS_ST_HOLD = 4'b0000,
    BTS_ST_OTP = 4'b0001,
    BTS_ST_REGRST = 4'b0010,
    BTS_ST_TRIM = 4'b0011,
    BTS_ST_SETTLE = 4'b0100,
    BTS_ST_CLK48 = 4'b0101,
    BTS_ST_PERSIST = 4'b0110,
    BTS_ST_ADDR = 4'b0111,
    BTS_ST_DEADBAT = 4'b1000,
    BTS_ST_FINAL = 4'b1001,
    BTS_ST_RUN = 4'b1010
  } bts_state_t;

endpackage

// ### core/bts_supervisor.sv
// Boot sequencer and thermal supervisor of a Type-C power controller
// Functional notes
// - Internal reset held until the 3.3 V regulator supply reports valid.
// - On release, enable core clocks and pulse the reset interrupt, start boot.
// - Boot sequence is fetched from OTP after each power-on reset.
// - Enable/reset registers, load trims, wait settle, then configure addresses.
// - Slave addresses come from OTP, debug control pins and strap resistor.
// - Address pins sampled once at boot, addresses never change afterwards.
// - Limited host interface opens once the addresses are fixed.
// - Dead battery flagged when external 3.3 V invalid and bus supply valid.
// - In dead battery, bus power select pin chooses the power routing.
// - Enable 48 MHz clock, then wait for either supply (bus or external 3.3 V) to persist stable.
// - Final step enables thermal, shutdown, ADC, CRC, GPIO, interrupt controller.
// - Central trip disables all but supervisory logic and halts the core.
// - Central trip release returns the device to normal operation.
// - Power path trip turns off power switches independently.
// - Each trip is deglitched for a fixed time before taking effect.
// - Each trip raises an interrupt to the core.
// - Core and USB 2.0 layer run on 48 MHz in normal operation.
// - 100 kHz clocks timers, and the core in low power.
// - General pins select push-pull, weak, open-drain, digital or analog input.
// - Pull-up and pull-down drive enables separate from the input path.
// - Port node input buffers on for digital monitoring, off for analog.
// - After dead battery path setup, boot continues with remaining stages.
`timescale 1ns/1ps
`default_nettype none
module bts_supervisor (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Supply monitors (asynchronous levels)
  input wire logic internal3v3Valid,
  input wire logic external3v3Valid,
  input wire logic busSupplyValid,
  // OTP boot interface
  output logic otpFetchReq,
  input wire logic otpFetchDone,
  input wire logic [bts_pkg::ADDR_W-1:0] otpAddr1,
  input wire logic [bts_pkg::ADDR_W-1:0] otpAddr2,
  input wire logic trimLoadDone,
  // Address strap pins (asynchronous levels)
  input wire logic [bts_pkg::DBG_W-1:0] debugControlPins,
  input wire logic [bts_pkg::STRAP_W-1:0] addrStrap,
  input wire logic busPowerPathSelectPin,
  // Thermal trips (asynchronous levels)
  input wire logic centralTripRaw,
  input wire logic powerPathTripRaw,
  // Core and clock control
  output logic coreResetN,
  output logic coreClkEn,
  output logic resetIrq,
  output logic coreHalt,
  output logic clk48En,
  output logic clk100kEn,
  output logic coreOn100k,
  output logic usbPhyClkEn,
  input wire logic lowPowerReq,
  // Boot outputs
  output logic regResetPulse,
  output logic trimLoadReq,
  output logic [bts_pkg::ADDR_W-1:0] i2cAddr1,
  output logic [bts_pkg::ADDR_W-1:0] i2cAddr2,
  output logic hostIfLimitedEn,
  output logic deadBattery,
  output logic busPowerRouteAlt,
  output logic bootDone,
  // Feature enables
  output logic thermalMonEn,
  output logic adcEn,
  output logic crcEn,
  output logic gpioEn,
  output logic intCtrlEn,
  // Thermal results
  output logic functionsOff,
  output logic powerSwitchOff,
  output logic centralTripIrq,
  output logic powerTripIrq,
  // General pin control
  input wire logic [3*bts_pkg::GPIO_N-1:0] gpioModeCfg,
  input wire logic [bts_pkg::GPIO_N-1:0] gpioOutVal,
  input wire logic [bts_pkg::GPIO_N-1:0] gpioPin,
  output logic [bts_pkg::GPIO_N-1:0] gpioPullUpEn,
  output logic [bts_pkg::GPIO_N-1:0] gpioPullDownEn,
  output logic [bts_pkg::GPIO_N-1:0] gpioWeakEn,
  output logic [bts_pkg::GPIO_N-1:0] gpioAnalogSel,
  output logic [bts_pkg::GPIO_N-1:0] gpioDigIn,
  // Port node buffers
  input wire logic [bts_pkg::PORT_N-1:0] portAnalogWanted,
  output logic [bts_pkg::PORT_N-1:0] portNodeBufEn
);
  import bts_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SYN_W = 4 + DBG_W + STRAP_W + GPIO_N;
  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  // Trip levels have their own pair below, no gate ahead of the first stage
  wire [SYN_W-1:0] synIn = {internal3v3Valid, external3v3Valid, busSupplyValid, busPowerPathSelectPin,
                            debugControlPins, addrStrap, gpioPin};
  logic [1:0] tsyn1_q;
  logic [1:0] tsyn2_q;

  // Two stages before any logic reads a pin
  always_ff @(posedge clk) begin
    if (srst) begin
      syn1_q <= '0;
      syn2_q <= '0;
      tsyn1_q <= '0;
      tsyn2_q <= '0;
    end else begin
      syn1_q <= synIn;
      syn2_q <= syn1_q;
      tsyn1_q <= {centralTripRaw, powerPathTripRaw};
      tsyn2_q <= tsyn1_q;
    end
  end

  wire int3v3Ok = syn2_q[SYN_W-1];
  wire ext3v3Ok = syn2_q[SYN_W-2];
  wire busOk = syn2_q[SYN_W-3];
  wire busPwrSel = syn2_q[SYN_W-4];
  wire [DBG_W-1:0] dbgSync = syn2_q[DBG_W+STRAP_W+GPIO_N-1:STRAP_W+GPIO_N];
  wire [STRAP_W-1:0] strapSync = syn2_q[STRAP_W+GPIO_N-1:GPIO_N];
  wire [GPIO_N-1:0] gpioSync = syn2_q[GPIO_N-1:0];

  // ****************************************
  // Thermal deglitch
  // ****************************************
  logic centralTrip;
  logic powerTrip;

  bts_trip_deglitch u_central_dg (
    .clk(clk),
    .srst(srst),
    .tripRaw(tsyn2_q[1]),
    .tripOut(centralTrip)
  );
  bts_trip_deglitch u_power_dg (
    .clk(clk),
    .srst(srst),
    .tripRaw(tsyn2_q[0]),
    .tripOut(powerTrip)
  );

  // ****************************************
  // Boot sequencer
  // ****************************************
  bts_state_t state_q;
  bts_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [ADDR_W-1:0] addr1_q;
  logic [ADDR_W-1:0] addr2_q;
  logic deadBat_q;
  logic busRoute_q;
  logic irq_q;

  // Address derivation shared by both ports
  function automatic logic [ADDR_W-1:0] mix_addr(input logic [ADDR_W-1:0] base,
                                                 input logic [DBG_W-1:0] dbg,
                                                 input logic [STRAP_W-1:0] strap);
    mix_addr = {base[ADDR_W-1:DBG_W+STRAP_W], dbg, strap};
  endfunction

  wire cntHit = cnt_q == CNT_W'(TRIM_SETTLE_CYC - 1);
  wire persistHit = cnt_q == CNT_W'(PERSIST_CYC - 1);
  wire suppliesOk = busOk || ext3v3Ok;

  // strict stage order, one step at a time
  always_comb begin
    state_d = state_q;
    cnt_d = '0;
    case (state_q)
      BTS_ST_HOLD: if (int3v3Ok) state_d = BTS_ST_OTP;
      BTS_ST_OTP: if (otpFetchDone) state_d = BTS_ST_REGRST;
      BTS_ST_REGRST: state_d = BTS_ST_TRIM;
      BTS_ST_TRIM: if (trimLoadDone) state_d = BTS_ST_SETTLE;
      BTS_ST_SETTLE: begin
        cnt_d = cntHit ? '0 : cnt_q + CNT_W'(1);
        if (cntHit) state_d = BTS_ST_CLK48;
      end
      BTS_ST_CLK48: state_d = BTS_ST_PERSIST;
      BTS_ST_PERSIST: begin
        cnt_d = suppliesOk ? cnt_q + CNT_W'(1) : '0;
        if (suppliesOk && persistHit) state_d = BTS_ST_ADDR;
      end
      BTS_ST_ADDR: state_d = BTS_ST_DEADBAT;
      BTS_ST_DEADBAT: state_d = BTS_ST_FINAL;
      BTS_ST_FINAL: state_d = BTS_ST_RUN;
      BTS_ST_RUN: state_d = BTS_ST_RUN;
      default: state_d = BTS_ST_HOLD;
    endcase
    if (!int3v3Ok) state_d = BTS_ST_HOLD;
  end

  // State, counter and sampled boot values
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= BTS_ST_HOLD;
      cnt_q <= '0;
      addr1_q <= ADDR1_BASE_RST;
      addr2_q <= ADDR2_BASE_RST;
      deadBat_q <= 1'b0;
      busRoute_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      irq_q <= state_q == BTS_ST_HOLD && state_d == BTS_ST_OTP;
      if (state_q == BTS_ST_ADDR) begin
        addr1_q <= mix_addr(otpAddr1, dbgSync, strapSync);
        addr2_q <= mix_addr(otpAddr2, dbgSync, strapSync);
      end
      // dead battery check and routing choice
      if (state_q == BTS_ST_DEADBAT) begin
        deadBat_q <= !ext3v3Ok && busOk;
        busRoute_q <= !ext3v3Ok && busOk && busPwrSel;
      end
    end
  end

  wire booting = state_q != BTS_ST_HOLD;
  wire pastAddr = state_q == BTS_ST_DEADBAT || state_q == BTS_ST_FINAL || state_q == BTS_ST_RUN;
  wire running = state_q == BTS_ST_RUN;
  wire clk48On = booting && !(state_q == BTS_ST_OTP || state_q == BTS_ST_REGRST ||
                              state_q == BTS_ST_TRIM || state_q == BTS_ST_SETTLE);

  // ****************************************
  // Outputs
  // ****************************************
  // core reset and clocks
  assign coreResetN = booting;
  assign coreClkEn = booting && !centralTrip;
  assign resetIrq = irq_q;
  assign otpFetchReq = state_q == BTS_ST_OTP;
  assign regResetPulse = state_q == BTS_ST_REGRST;
  assign trimLoadReq = state_q == BTS_ST_TRIM;
  // 48 MHz for core and USB layer
  assign clk48En = clk48On && !centralTrip && !lowPowerReq;
  assign usbPhyClkEn = clk48En;
  // slow clock for timers and low power core
  assign clk100kEn = booting;
  assign coreOn100k = booting && lowPowerReq;
  assign i2cAddr1 = addr1_q;
  assign i2cAddr2 = addr2_q;
  assign hostIfLimitedEn = pastAddr && !centralTrip;
  assign deadBattery = deadBat_q;
  assign busPowerRouteAlt = busRoute_q;
  assign bootDone = running;
  // final stage enables, ADC, CRC and GPIO dropped on central trip
  assign thermalMonEn = running;
  assign adcEn = running && !centralTrip;
  assign crcEn = running && !centralTrip;
  assign gpioEn = running && !centralTrip;
  assign intCtrlEn = running;
  assign functionsOff = centralTrip;
  assign coreHalt = centralTrip;
  assign powerSwitchOff = powerTrip;

  // ****************************************
  // Trip interrupts
  // ****************************************
  logic cTripLast_q;
  logic pTripLast_q;

  // Edge record for interrupt pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      cTripLast_q <= 1'b0;
      pTripLast_q <= 1'b0;
    end else begin
      cTripLast_q <= centralTrip;
      pTripLast_q <= powerTrip;
    end
  end

  assign centralTripIrq = centralTrip && !cTripLast_q;
  assign powerTripIrq = powerTrip && !pTripLast_q;

  // ****************************************
  // General pins and port buffers
  // ****************************************
  // per pin drive and input selection
  genvar g;
  for (g = 0; g < GPIO_N; g++) begin : gpioCtl
    wire [2:0] mode = gpioModeCfg[3*g+2:3*g];
    wire drives = mode == BTS_PIN_PUSH || mode == BTS_PIN_WEAK;
    assign gpioPullUpEn[g] = gpioEn && drives && gpioOutVal[g];
    assign gpioPullDownEn[g] = gpioEn && (drives || mode == BTS_PIN_ODRAIN) && !gpioOutVal[g];
    assign gpioWeakEn[g] = mode == BTS_PIN_WEAK;
    assign gpioAnalogSel[g] = mode == BTS_PIN_IN_ANA;
    assign gpioDigIn[g] = mode != BTS_PIN_IN_ANA && gpioSync[g];
  end

  assign portNodeBufEn = running ? ~portAnalogWanted : '0;

endmodule
`default_nettype wire

// ### core/bts_trip_deglitch.sv
// Deglitch filter for one synchronised thermal trip level
`timescale 1ns/1ps
`default_nettype none
module bts_trip_deglitch (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Trip level in and filtered level out
  input wire logic tripRaw,
  output logic tripOut
);
  import bts_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic out_q;
  logic out_d;
  wire differs = tripRaw != out_q;
  wire expired = cnt_q == CNT_W'(TRIP_DEGLITCH_CYC - 1);

  // Output follows only after the level held the whole window
  assign cnt_d = (!differs || expired) ? '0 : cnt_q + CNT_W'(1);
  assign out_d = (differs && expired) ? tripRaw : out_q;

  // Counter and filtered level
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign tripOut = out_q;
endmodule
`default_nettype wire

// ### test/bts_otp_model.sv
// Behavioural model of the OTP and trim store that answers the sequencer
`timescale 1ns/1ps
`default_nettype none
module bts_otp_model #(
  parameter int LAT = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Requests from the sequencer
  input wire logic otpFetchReq,
  input wire logic trimLoadReq,
  // Completion levels back
  output logic otpFetchDone,
  output logic trimLoadDone
);
  logic [7:0] wait_q;
  // Count request age; drop at once when the request goes, so no stale done
  always_ff @(posedge clk) begin
    if (srst || !(otpFetchReq || trimLoadReq)) wait_q <= 8'h00;
    else if (wait_q != 8'hFF) wait_q <= wait_q + 8'h01;
  end
  // Done only after LAT cycles, a slow store is one larger LAT
  assign otpFetchDone = otpFetchReq && (wait_q >= 8'(LAT));
  assign trimLoadDone = trimLoadReq && (wait_q >= 8'(LAT));
endmodule
`default_nettype wire

// ### test/bts_supervisor_bench.sv
// Self-checking bench for the boot and thermal supervisor
`timescale 1ns/1ps
`default_nettype none
module bts_supervisor_bench;
  import bts_pkg::*;
  typedef struct packed {bts_pin_mode_t mode; logic [7:0] pu, pd, wk, an;} bts_row_t;
  logic clk, srst, internal3v3Valid, external3v3Valid, busSupplyValid, otpFetchReq, otpFetchDone, trimLoadDone;
  logic busPowerPathSelectPin, centralTripRaw, powerPathTripRaw, coreResetN, coreClkEn, resetIrq, coreHalt;
  logic clk48En, clk100kEn, coreOn100k, usbPhyClkEn, lowPowerReq, regResetPulse, trimLoadReq, hostIfLimitedEn;
  logic deadBattery, busPowerRouteAlt, bootDone, thermalMonEn, adcEn, crcEn, gpioEn, intCtrlEn;
  logic functionsOff, powerSwitchOff, centralTripIrq, powerTripIrq;
  logic [ADDR_W-1:0] otpAddr1, otpAddr2, i2cAddr1, i2cAddr2;
  logic [DBG_W-1:0] debugControlPins;
  logic [STRAP_W-1:0] addrStrap;
  logic [3*GPIO_N-1:0] gpioModeCfg;
  logic [GPIO_N-1:0] gpioOutVal, gpioPin, gpioPullUpEn, gpioPullDownEn, gpioWeakEn, gpioAnalogSel, gpioDigIn;
  logic [PORT_N-1:0] portAnalogWanted, portNodeBufEn;
  int numErrors, samplesChecked, n;
  // Pin mode rows: mode, pull-up, pull-down, weak, analog for drive value A5
  bts_row_t rows [5] = '{'{BTS_PIN_IN_DIG, 8'h00, 8'h00, 8'h00, 8'h00},
    '{BTS_PIN_IN_ANA, 8'h00, 8'h00, 8'h00, 8'hFF}, '{BTS_PIN_PUSH, 8'hA5, 8'h5A, 8'h00, 8'h00},
    '{BTS_PIN_WEAK, 8'hA5, 8'h5A, 8'hFF, 8'h00}, '{BTS_PIN_ODRAIN, 8'h00, 8'h5A, 8'h00, 8'h00}};
  bts_supervisor DUT (.clk, .srst, .internal3v3Valid, .external3v3Valid, .busSupplyValid, .otpFetchReq,
    .otpFetchDone, .otpAddr1, .otpAddr2, .trimLoadDone, .debugControlPins, .addrStrap, .busPowerPathSelectPin,
    .centralTripRaw, .powerPathTripRaw, .coreResetN, .coreClkEn, .resetIrq, .coreHalt, .clk48En, .clk100kEn,
    .coreOn100k, .usbPhyClkEn, .lowPowerReq, .regResetPulse, .trimLoadReq, .i2cAddr1, .i2cAddr2,
    .hostIfLimitedEn, .deadBattery, .busPowerRouteAlt, .bootDone, .thermalMonEn, .adcEn, .crcEn, .gpioEn,
    .intCtrlEn, .functionsOff, .powerSwitchOff, .centralTripIrq, .powerTripIrq, .gpioModeCfg, .gpioOutVal,
    .gpioPin, .gpioPullUpEn, .gpioPullDownEn, .gpioWeakEn, .gpioAnalogSel, .gpioDigIn, .portAnalogWanted,
    .portNodeBufEn);
  // Slow store answers, so the sequencer must really wait
  bts_otp_model #(.LAT(4)) u_otp (.clk, .srst, .otpFetchReq, .trimLoadReq, .otpFetchDone, .trimLoadDone);
  // Free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic closeOut();
    $display("Samples checked %0d, mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = resetIrq;
      1: pick = bootDone;
      2: pick = coreHalt;
      3: pick = !coreHalt;
      default: pick = powerSwitchOff;
    endcase
  endfunction
  // Bounded wait on a design flag, sampled at the falling edge
  task automatic waitFor(input int w, input int lim, output int cnt);
    cnt = 0;
    while (pick(w) !== 1'b1) begin
      @(negedge clk);
      cnt++;
      if (cnt > lim) begin
        chk("waitFlag", 24'(w), 24'hFFFFFF);
        closeOut();
      end
    end
  endtask
  task automatic doReset();
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    numErrors = 0;
    samplesChecked = 0;
    {internal3v3Valid, external3v3Valid, centralTripRaw, powerPathTripRaw, lowPowerReq} = 5'h00;
    {busSupplyValid, busPowerPathSelectPin} = 2'h3;
    otpAddr1 = 7'h50;
    otpAddr2 = 7'h71;
    debugControlPins = 2'h2;
    addrStrap = 2'h1;
    gpioModeCfg = 24'h000000;
    gpioOutVal = 8'h00;
    gpioPin = 8'h00;
    portAnalogWanted = 6'h00;
    doReset();
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("coreResetN", 24'h0, coreResetN);
    chk("i2cAddr1", 24'(ADDR1_BASE_RST), i2cAddr1);
    @(posedge clk) internal3v3Valid <= 1'b1;
    waitFor(0, 20, n);
    chk("coreClkEn", 24'h1, coreClkEn);
    waitFor(1, 1000, n);
    chk("bootWait", 24'h1, 24'(n >= PERSIST_CYC));
    chk("i2cAddr1", 24'h59, i2cAddr1);
    chk("i2cAddr2", 24'h79, i2cAddr2);
    chk("deadBatRoute", 24'h3, {deadBattery, busPowerRouteAlt});
    chk("enables", 24'h7F, {hostIfLimitedEn, thermalMonEn, adcEn, crcEn, gpioEn, intCtrlEn, usbPhyClkEn});
    @(posedge clk) debugControlPins <= 2'h1;
    addrStrap <= 2'h2;
    lowPowerReq <= 1'b1;
    portAnalogWanted <= 6'h15;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("i2cAddr1", 24'h59, i2cAddr1);
    chk("lowPowerClk", 24'h6, {coreOn100k, clk100kEn, clk48En});
    chk("portNodeBufEn", 24'h2A, portNodeBufEn);
    @(posedge clk) lowPowerReq <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) gpioModeCfg <= {8{rows[i].mode}};
      gpioOutVal <= 8'hA5;
      gpioPin <= 8'h3C;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("gpioPullUpEn", 24'(rows[i].pu), gpioPullUpEn);
      chk("gpioPullDownEn", 24'(rows[i].pd), gpioPullDownEn);
      chk("gpioWeakEn", 24'(rows[i].wk), gpioWeakEn);
      chk("gpioAnalogSel", 24'(rows[i].an), gpioAnalogSel);
      if (rows[i].mode == BTS_PIN_IN_DIG) chk("gpioDigIn", 24'h3C, gpioDigIn);
    end
    // A trip shorter than the deglitch time must be ignored
    @(posedge clk) centralTripRaw <= 1'b1;
    repeat (50) @(posedge clk);
    centralTripRaw <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("coreHalt", 24'h0, coreHalt);
    @(posedge clk) centralTripRaw <= 1'b1;
    waitFor(2, 300, n);
    chk("tripWait", 24'h1, 24'(n >= TRIP_DEGLITCH_CYC));
    chk("haltState", 24'h4, {functionsOff, adcEn, coreClkEn});
    @(posedge clk) centralTripRaw <= 1'b0;
    waitFor(3, 300, n);
    @(negedge clk);
    chk("resume", 24'h7, {adcEn, coreClkEn, clk48En});
    @(posedge clk) powerPathTripRaw <= 1'b1;
    waitFor(4, 300, n);
    chk("powerTripOnly", 24'h1, {coreHalt, adcEn});
    @(posedge clk) powerPathTripRaw <= 1'b0;
    external3v3Valid <= 1'b1;
    @(posedge clk) doReset();
    waitFor(1, 1000, n);
    chk("deadBattery", 24'h0, {deadBattery, busPowerRouteAlt});
    closeOut();
  end
endmodule
`default_nettype wire

// ### test/bts_supervisor_checker.sv
// Assertion checker bound to the boot and thermal supervisor ports
`timescale 1ns/1ps
`default_nettype none
module bts_supervisor_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Boot and core control
  input wire logic centralTripRaw,
  input wire logic coreResetN,
  input wire logic coreClkEn,
  input wire logic resetIrq,
  input wire logic coreHalt,
  input wire logic clk48En,
  input wire logic regResetPulse,
  input wire logic trimLoadReq,
  input wire logic [bts_pkg::ADDR_W-1:0] i2cAddr1,
  input wire logic [bts_pkg::ADDR_W-1:0] i2cAddr2,
  input wire logic hostIfLimitedEn,
  input wire logic bootDone,
  // Feature enables and thermal results
  input wire logic thermalMonEn,
  input wire logic adcEn,
  input wire logic crcEn,
  input wire logic gpioEn,
  input wire logic intCtrlEn,
  input wire logic functionsOff,
  input wire logic powerSwitchOff,
  input wire logic centralTripIrq,
  input wire logic powerTripIrq,
  // Port node buffers
  input wire logic [bts_pkg::PORT_N-1:0] portAnalogWanted,
  input wire logic [bts_pkg::PORT_N-1:0] portNodeBufEn
);
  import bts_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [CNT_W-1:0] cenRun_q;
  // Length of the current raw trip run, saturating
  always_ff @(posedge clk) begin
    if (srst || !centralTripRaw) cenRun_q <= '0;
    else if (cenRun_q != '1) cenRun_q <= cenRun_q + 12'h001;
  end
  property p_hold; !coreResetN |-> !coreClkEn && !bootDone && !hostIfLimitedEn; endproperty
  a_hold: assert property (p_hold)
    else $error("core active while held in reset");
  property p_irq; resetIrq |-> coreResetN ##1 !resetIrq; endproperty
  a_irq: assert property (p_irq)
    else $error("reset interrupt not a single pulse after release");
  property p_trim; $rose(trimLoadReq) |-> $past(regResetPulse); endproperty
  a_trim: assert property (p_trim)
    else $error("trim load not preceded by register reset");
  property p_addr; bootDone && $past(bootDone) |-> $stable(i2cAddr1) && $stable(i2cAddr2); endproperty
  a_addr: assert property (p_addr)
    else $error("address changed after boot");
  property p_tail; $rose(hostIfLimitedEn) |-> ##2 bootDone; endproperty
  a_tail: assert property (p_tail)
    else $error("boot did not finish two cycles after host open");
  property p_final; bootDone && !coreHalt |-> thermalMonEn && intCtrlEn && adcEn && crcEn && gpioEn; endproperty
  a_final: assert property (p_final)
    else $error("feature enable missing after boot");
  property p_halt; coreHalt |-> functionsOff && !coreClkEn && !adcEn && !clk48En; endproperty
  a_halt: assert property (p_halt)
    else $error("function still on during central trip");
  property p_cirq; $rose(coreHalt) |-> centralTripIrq ##1 !centralTripIrq; endproperty
  a_cirq: assert property (p_cirq)
    else $error("central trip interrupt wrong");
  property p_pirq; $rose(powerSwitchOff) |-> powerTripIrq ##1 !powerTripIrq; endproperty
  a_pirq: assert property (p_pirq)
    else $error("power trip interrupt wrong");
  property p_dgl; $rose(coreHalt) |-> cenRun_q >= TRIP_DEGLITCH_CYC; endproperty
  a_dgl: assert property (p_dgl)
    else $error("central trip taken before deglitch time");
  property p_clk48; $rose(clk48En) && !bootDone |-> !hostIfLimitedEn [*8]; endproperty
  a_clk48: assert property (p_clk48)
    else $error("boot ran on without supply persistence");
  property p_buf; bootDone |-> portNodeBufEn == ~portAnalogWanted; endproperty
  a_buf: assert property (p_buf)
    else $error("port node buffer enable wrong");
endmodule
bind bts_supervisor bts_supervisor_checker u_chk (.clk, .srst, .centralTripRaw, .coreResetN, .coreClkEn,
  .resetIrq, .coreHalt, .clk48En, .regResetPulse, .trimLoadReq, .i2cAddr1, .i2cAddr2, .hostIfLimitedEn,
  .bootDone, .thermalMonEn, .adcEn, .crcEn, .gpioEn, .intCtrlEn, .functionsOff, .powerSwitchOff,
  .centralTripIrq, .powerTripIrq, .portAnalogWanted, .portNodeBufEn);
`default_nettype wire
